// ==== rtc_host_pkg.sv ====
// Package with constants, types and layouts for the clock host port.
package rtc_host_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int CLK_LOCS = 64;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_COUNT = 128;
    localparam logic [5:0] LOC_SECONDS = 6'h00;
    localparam logic [5:0] LOC_REG_A = 6'h0a;
    localparam logic [5:0] LOC_REG_B = 6'h0b;
    localparam logic [5:0] LOC_REG_C = 6'h0c;
    localparam logic [5:0] LOC_REG_D = 6'h0d;
    localparam int BIT_TOP = 7;
    localparam int BIT_SQW_EN = 3;
    localparam int BIT_UPD_EN = 4;
    localparam int BIT_ALARM_EN = 5;
    localparam int BIT_PER_EN = 6;
    localparam int BIT_UPD_FLAG = 4;
    localparam int BIT_ALARM_FLAG = 5;
    localparam int BIT_PER_FLAG = 6;
    localparam int BIT_IRQ_SUM = 7;
    localparam int ADDR_SEL_BIT = 5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] REG_D_VAL = 8'h80;
    localparam logic [3:0] RATE_OFF = 4'h0;
    localparam int RATE_MIN_SHIFT = 2;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic rtc_n;
        logic ext_ram_n;
        logic standby_n;
        logic rst_n;
    } bus_ctl_s;

    typedef struct packed {
        logic alarm;
        logic update_done;
        logic periodic;
    } rtc_event_s;
endpackage

// ==== sync2.sv ====
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clk_i,               // System clock.
    input wire logic nrst_i,              // Asynchronous reset, low.
    input wire logic [WIDTH-1:0] async_i, // Asynchronous levels.
    output logic [WIDTH-1:0] sync_o       // Synchronised levels.
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= INIT;
            sync_o <= INIT;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== sqw_divider.sv ====
// Square-wave generator with a 4-bit rate select.
`timescale 1ns/100ps
`default_nettype none
module sqw_divider
    import rtc_host_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk_i,        // System clock.
    input wire logic nrst_i,       // Asynchronous reset, low.
    input wire logic tick_i,       // Time base tick.
    input wire logic [3:0] rate_i, // Rate select.
    output logic wave_o,           // Divided square wave.
    output logic periodic_o        // One pulse per output period.
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tap;

    assign cnt_next = cnt_reg + DIV_W'(1);
    // Rate n takes divider tap n-1 plus a fixed offset; zero stops the wave.
    assign tap = (rate_i == RATE_OFF) ? 1'b0 :
        cnt_reg[(DIV_W'(rate_i) + DIV_W'(RATE_MIN_SHIFT) - DIV_W'(1))
        % DIV_W];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
        end else if (tick_i) begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wave_o <= 1'b0;
            periodic_o <= 1'b0;
        end else begin
            wave_o <= tap;
            periodic_o <= tap & ~wave_o;
        end
    end
endmodule
`default_nettype wire

// ==== rtc_host_bus_interface.sv ====
// Parallel host port of a real-time clock with paged extended RAM.
`timescale 1ns/100ps
`default_nettype none
module rtc_host_bus_interface
    import rtc_host_pkg::*;
#(
    parameter int PAGES = PAGE_COUNT
) (
    input wire logic clk_i,              // System clock, 10 MHz.
    input wire logic nrst_i,             // Asynchronous reset, low.
    input wire logic [ADDR_W-1:0] addr_i, // Address lines.
    input wire logic [DATA_W-1:0] data_i, // Data bus input.
    output logic [DATA_W-1:0] data_o,    // Data bus output.
    output logic data_oe_o,              // Data bus drive enable.
    input wire logic rd_n_i,             // Read strobe, low.
    input wire logic wr_n_i,             // Write strobe, low.
    input wire logic rtc_select_n_i,     // Clock register select, low.
    input wire logic ext_ram_select_n_i, // Extended RAM select, low.
    input wire logic standby_n_i,        // Standby, low.
    input wire logic reset_n_i,          // Register reset pin, low.
    input wire logic time_tick_i,        // Time base tick.
    input wire rtc_event_s events_i,     // Alarm/update event pulses.
    output logic irq_n_o,                // Interrupt pin level (always 0).
    output logic irq_oe_o,               // Interrupt pin pull-down enable.
    output logic sqw_o,                  // Square wave.
    output logic [DATA_W-1:0] ctl_b_o    // Control register B contents.
);
    localparam int PAGE_W = $clog2(PAGES);
    localparam int RAM_W = PAGE_W + 5;

    ////////////////////////////////////////////////////////////////////////
    bus_ctl_s raw_ctl;
    bus_ctl_s ctl;
    logic [ADDR_W-1:0] addr_s;
    logic [ADDR_W-1:0] addr_m;
    logic [DATA_W-1:0] din_s;
    logic [DATA_W-1:0] din_m;

    assign raw_ctl = '{rd_n: rd_n_i, wr_n: wr_n_i, rtc_n: rtc_select_n_i,
        ext_ram_n: ext_ram_select_n_i, standby_n: standby_n_i,
        rst_n: reset_n_i};

    sync2 #(.WIDTH(6)) u_ctl_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(raw_ctl),
        .sync_o(ctl)
    );

    // Address and data are held stable around a strobe edge by the host.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_m <= '0;
            addr_s <= '0;
            din_m <= '0;
            din_s <= '0;
        end else begin
            addr_m <= addr_i;
            addr_s <= addr_m;
            din_m <= data_i;
            din_s <= din_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic rtc_sel;
    logic ext_ram_sel;
    logic wr_n_d_reg;
    logic wr_pulse;
    logic sel_held_reg;
    logic rtc_held_reg;

    // Standby gates both selects; a write in flight dies with them.
    assign rtc_sel = ~ctl.rtc_n & ctl.standby_n & ctl.rst_n;
    assign ext_ram_sel = ~ctl.ext_ram_n & ctl.standby_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_n_d_reg <= 1'b1;
            sel_held_reg <= 1'b0;
            rtc_held_reg <= 1'b0;
        end else begin
            wr_n_d_reg <= ctl.wr_n;
            sel_held_reg <= (rtc_sel | ext_ram_sel) & ~ctl.wr_n;
            rtc_held_reg <= rtc_sel & ~ctl.wr_n;
        end
    end

    // The write lands on the rising strobe edge; the select must still be
    // present, so standby, or reset for a clock write, ending the cycle early cancels it.
    assign wr_pulse = ctl.wr_n & ~wr_n_d_reg & sel_held_reg;

    ////////////////////////////////////////////////////////////////////////
    logic [5:0] index_reg;
    logic [PAGE_W-1:0] page_reg;
    logic [DATA_W-1:0] clk_mem [CLK_LOCS];
    logic [DATA_W-1:0] ram_mem [PAGES*PAGE_BYTES];
    logic [RAM_W-1:0] ram_addr;
    logic rtc_wr;
    logic ext_ram_wr;
    logic data_wr;
    logic page_wr;
    logic ram_wr;

    assign rtc_wr = wr_pulse & rtc_held_reg & ctl.rst_n;
    assign ext_ram_wr = wr_pulse & ~rtc_held_reg;
    assign data_wr = rtc_wr & addr_s[0];
    assign page_wr = ext_ram_wr & addr_s[ADDR_SEL_BIT];
    assign ram_wr = ext_ram_wr & ~addr_s[ADDR_SEL_BIT];
    assign ram_addr = {page_reg, addr_s[4:0]};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            index_reg <= '0;
        end else if (rtc_wr & ~addr_s[0]) begin
            index_reg <= din_s[5:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_reg <= '0;
        end else if (page_wr) begin
            page_reg <= din_s[PAGE_W-1:0];
        end
    end

    // Contents survive standby and reset: only writes change them.
    always_ff @(posedge clk_i) begin
        if (ram_wr) begin
            ram_mem[ram_addr] <= din_s;
        end
    end

    // General locations and A, B; seconds bit 7 is forced to 0 here, C and D are skipped; A to D read from below.
    always_ff @(posedge clk_i) begin
        if (data_wr && index_reg != LOC_REG_C && index_reg != LOC_REG_D) begin
            if (index_reg == LOC_SECONDS) begin
                clk_mem[index_reg] <= {1'b0, din_s[BIT_TOP-1:0]};
            end else begin
                clk_mem[index_reg] <= din_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] ctl_a_reg;
    logic [DATA_W-1:0] flags_reg;
    logic reg_b_wr;
    logic reg_c_rd;
    logic rd_act;
    logic rd_act_d_reg;
    logic periodic_ev;
    logic [2:0] pend;
    logic sqw_raw;

    assign reg_b_wr = data_wr && index_reg == LOC_REG_B;
    assign rd_act = ~ctl.rd_n & (rtc_sel | ext_ram_sel);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_act_d_reg <= 1'b0;
        end else begin
            rd_act_d_reg <= rd_act & rtc_sel & addr_s[0];
        end
    end

    // Status C clears after the read cycle that showed it ends.
    assign reg_c_rd = rd_act_d_reg & ~(rd_act & rtc_sel)
        && index_reg == LOC_REG_C;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl_a_reg <= ZERO_BYTE;
        end else if (data_wr && index_reg == LOC_REG_A) begin
            ctl_a_reg <= {ctl_a_reg[BIT_TOP], din_s[BIT_TOP-1:0]};
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl_b_o <= ZERO_BYTE;
        end else if (!ctl.rst_n) begin
            ctl_b_o[BIT_PER_EN] <= 1'b0;
            ctl_b_o[BIT_ALARM_EN] <= 1'b0;
            ctl_b_o[BIT_UPD_EN] <= 1'b0;
            ctl_b_o[BIT_SQW_EN] <= 1'b0;
        end else if (reg_b_wr) begin
            ctl_b_o <= din_s;
        end
    end

    sqw_divider u_sqw (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(time_tick_i),
        .rate_i(ctl_a_reg[3:0]),
        .wave_o(sqw_raw),
        .periodic_o(periodic_ev)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sqw_o <= 1'b0;
        end else begin
            sqw_o <= sqw_raw & ctl_b_o[BIT_SQW_EN];
        end
    end

    assign pend = {flags_reg[BIT_PER_FLAG] & ctl_b_o[BIT_PER_EN],
        flags_reg[BIT_ALARM_FLAG] & ctl_b_o[BIT_ALARM_EN],
        flags_reg[BIT_UPD_FLAG] & ctl_b_o[BIT_UPD_EN]};

    // Event sets beat the read clear; reset pin clears all flags.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_reg <= ZERO_BYTE;
        end else if (!ctl.rst_n) begin
            flags_reg <= ZERO_BYTE;
        end else begin
            flags_reg[BIT_PER_FLAG] <= periodic_ev
                | (flags_reg[BIT_PER_FLAG] & ~reg_c_rd);
            flags_reg[BIT_ALARM_FLAG] <= events_i.alarm
                | (flags_reg[BIT_ALARM_FLAG] & ~reg_c_rd);
            flags_reg[BIT_UPD_FLAG] <= events_i.update_done
                | (flags_reg[BIT_UPD_FLAG] & ~reg_c_rd);
            // The summary must see the clear as well, or the enabled flags
            // still standing in the clearing cycle would set it again.
            flags_reg[BIT_IRQ_SUM] <= ((|pend) | flags_reg[BIT_IRQ_SUM])
                & ~reg_c_rd;
        end
    end

    // Open drain: the pin only ever pulls low; reset releases it.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_oe_o <= 1'b0;
            irq_n_o <= 1'b0;
        end else begin
            irq_oe_o <= flags_reg[BIT_IRQ_SUM] & ctl.rst_n;
            irq_n_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] clk_rd;

    always_comb begin
        case (index_reg)
            LOC_REG_A: clk_rd = ctl_a_reg;
            LOC_REG_B: clk_rd = ctl_b_o;
            LOC_REG_C: clk_rd = flags_reg;
            LOC_REG_D: clk_rd = REG_D_VAL;
            default: clk_rd = clk_mem[index_reg];
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o <= ZERO_BYTE;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= rd_act;
            if (rtc_sel) begin
                data_o <= addr_s[0] ? clk_rd : {2'b00, index_reg};
            end else if (addr_s[ADDR_SEL_BIT]) begin
                data_o <= {{(DATA_W-PAGE_W){1'b0}}, page_reg};
            end else begin
                data_o <= ram_mem[ram_addr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_irq_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_oe_o |-> $past(flags_reg[BIT_IRQ_SUM]))
        else $error("irq driven without summary flag");
    chk_irq_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_oe_o |-> !irq_n_o)
        else $error("irq pin driven high");
    chk_standby_float: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl.standby_n ##1 !ctl.standby_n |-> !data_oe_o)
        else $error("data driven in standby");
    chk_read_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_act |=> data_oe_o)
        else $error("read not driven");
    chk_reset_enables: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl.rst_n |=> ctl_b_o[BIT_PER_EN:BIT_UPD_EN] == 3'b000
        && !ctl_b_o[BIT_SQW_EN])
        else $error("enables not cleared in reset");
    chk_reset_flags: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl.rst_n |=> flags_reg == ZERO_BYTE)
        else $error("flags not cleared in reset");
    chk_reset_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl.rst_n |=> !irq_oe_o)
        else $error("irq active in reset");
    chk_reset_reject: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl.rst_n |-> !rtc_wr)
        else $error("clock write during reset");
    chk_flag_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        events_i.alarm && ctl.rst_n |=> flags_reg[BIT_ALARM_FLAG])
        else $error("alarm flag lost");
    chk_sqw_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctl_b_o[BIT_SQW_EN] |=> !sqw_o)
        else $error("square wave without enable");
endmodule
`default_nettype wire

// ==== host_bus_model.sv ====
// Host processor model that runs byte cycles on the parallel bus.
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    input wire logic clk_i,       // System clock.
    input wire logic [7:0] bus_i, // Resolved data bus.
    input wire logic oe_i,        // Device drives the bus.
    output logic [5:0] addr_o,    // Address lines.
    output logic [7:0] dat_o,     // Host write data.
    output logic dat_en_o,        // Host drives the bus.
    output logic rd_n_o,          // Read strobe, low.
    output logic wr_n_o,          // Write strobe, low.
    output logic rtc_n_o,         // Clock select, low.
    output logic ext_ram_n_o      // RAM select, low.
);
    initial begin
        addr_o = 6'h00;
        dat_o = 8'h00;
        dat_en_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        rtc_n_o = 1'b1;
        ext_ram_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Only one select is ever low, and never both strobes together.
    task automatic start(input logic ram, input logic [5:0] a);
        @(posedge clk_i);
        #1;
        rtc_n_o = ram;
        ext_ram_n_o = ~ram;
        addr_o = a;
    endtask

    // Released address lines wander so stale decode cannot help.
    task automatic finish();
        #1;
        rtc_n_o = 1'b1;
        ext_ram_n_o = 1'b1;
        dat_en_o = 1'b0;
        addr_o = ~addr_o;
        repeat (3) @(posedge clk_i);
        // Callers go on driving inputs, so return just off the edge.
        #1;
    endtask

    task automatic write_byte(input logic ram, input logic [5:0] a,
                              input logic [7:0] d);
        start(ram, a);
        dat_o = d;
        dat_en_o = 1'b1;
        wr_n_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        wr_n_o = 1'b1;
        repeat (4) @(posedge clk_i);
        finish();
    endtask

    task automatic read_byte(input logic ram, input logic [5:0] a,
                             output logic [7:0] d, output logic drv);
        start(ram, a);
        rd_n_o = 1'b0;
        repeat (6) @(posedge clk_i);
        d = bus_i;
        drv = oe_i;
        #1;
        rd_n_o = 1'b1;
        repeat (4) @(posedge clk_i);
        finish();
    endtask
endmodule
`default_nettype wire

// ==== test_rtc_host_bus_interface.sv ====
// Self-checking bench for the clock host port.
`timescale 1ns/100ps
`default_nettype none
module test_rtc_host_bus_interface
    import rtc_host_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic standby_n = 1'b1;
    logic reset_n = 1'b1;
    logic tick = 1'b0;
    rtc_event_s ev = '0;
    logic [5:0] addr;
    logic [7:0] hdat, dout, bus, ctl_b;
    logic [7:0] bus_last = 8'h00;
    logic hen, doe, rd_n, wr_n, rtc_n, ext_ram_n, irq_n, irq_oe, sqw;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;
    // A floating bus shows a changing pattern, so stale data never passes.
    assign bus = doe ? dout : (hen ? hdat : ~bus_last);
    always @(posedge clk_i) bus_last <= bus;
    wire logic irq_line = irq_oe ? irq_n : 1'b1;
    always @(posedge clk_i) begin
        #1;
        tick = ~tick;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    rtc_host_bus_interface u_rtc_host_bus_interface (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .data_i(bus),
        .data_o(dout), .data_oe_o(doe), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .rtc_select_n_i(rtc_n), .ext_ram_select_n_i(ext_ram_n),
        .standby_n_i(standby_n), .reset_n_i(reset_n),
        .time_tick_i(tick), .events_i(ev), .irq_n_o(irq_n),
        .irq_oe_o(irq_oe), .sqw_o(sqw), .ctl_b_o(ctl_b));
    host_bus_model u_host_bus_model (
        .clk_i(clk_i), .bus_i(bus), .oe_i(doe), .addr_o(addr),
        .dat_o(hdat), .dat_en_o(hen), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .rtc_n_o(rtc_n), .ext_ram_n_o(ext_ram_n));

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic pulse(input rtc_event_s e);
        @(posedge clk_i);
        #1;
        ev = e;
        @(posedge clk_i);
        #1;
        ev = '0;
    endtask

    task automatic rd(input string what, input logic ram,
                      input logic [5:0] a, input logic [7:0] exp,
                      input logic [7:0] m, input logic drive);
        logic [7:0] d;
        logic drv;
        u_host_bus_model.read_byte(ram, a, d, drv);
        check({what, " drive"}, {7'h00, drive}, {7'h00, drv});
        if (drive) check(what, exp, d & m);
    endtask

    task automatic cwr(input logic [5:0] idx, input logic [7:0] d);
        u_host_bus_model.write_byte(1'b0, 6'h00, {2'b00, idx});
        u_host_bus_model.write_byte(1'b0, 6'h01, d);
    endtask

    task automatic crd(input string what, input logic [5:0] idx,
                       input logic [7:0] exp, input logic [7:0] m);
        u_host_bus_model.write_byte(1'b0, 6'h00, {2'b00, idx});
        rd(what, 1'b0, 6'h01, exp, m, 1'b1);
    endtask

    task automatic level(input logic v, inout int n);
        while (sqw !== v && n < 4000) begin
            wait_cycles(1);
            n++;
        end
    endtask

    task automatic period(output int n);
        n = 0;
        level(1'b0, n);
        level(1'b1, n);
        n = 0;
        level(1'b0, n);
        level(1'b1, n);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        wait_cycles(2);
        check("ctl b", 8'h00, ctl_b);
        check("irq oe", 8'h00, {7'h00, irq_oe});
        check("data oe", 8'h00, {7'h00, doe});
        $display("test reset done");
    endtask

    task automatic t_index();
        logic [5:0] idx[3] = '{6'h0e, 6'h25, 6'h3f};
        for (int i = 0; i < 3; i++) begin
            cwr(idx[i], 8'h5a ^ {2'b00, idx[i]});
        end
        for (int i = 0; i < 3; i++) begin
            crd("clock byte", idx[i], 8'h5a ^ {2'b00, idx[i]}, 8'hff);
        end
        $display("test index done");
    endtask

    task automatic t_readonly();
        cwr(LOC_REG_D, 8'h00);
        crd("reg d", LOC_REG_D, REG_D_VAL, 8'hff);
        cwr(LOC_REG_C, 8'hff);
        crd("reg c", LOC_REG_C, 8'h00, 8'hff);
        cwr(LOC_SECONDS, 8'hff);
        crd("seconds", LOC_SECONDS, 8'h7f, 8'hff);
        cwr(LOC_REG_A, 8'h80);
        crd("reg a", LOC_REG_A, 8'h00, 8'hff);
        $display("test readonly done");
    endtask

    task automatic t_pages();
        u_host_bus_model.write_byte(1'b1, 6'h20, 8'h03);
        u_host_bus_model.write_byte(1'b1, 6'h05, 8'ha5);
        u_host_bus_model.write_byte(1'b1, 6'h3f, 8'h7f);
        u_host_bus_model.write_byte(1'b1, 6'h05, 8'h3c);
        rd("page alias", 1'b1, 6'h2a, 8'h7f, 8'hff, 1'b1);
        rd("page 127 byte", 1'b1, 6'h05, 8'h3c, 8'hff, 1'b1);
        u_host_bus_model.write_byte(1'b1, 6'h21, 8'h03);
        rd("page 3 byte", 1'b1, 6'h05, 8'ha5, 8'hff, 1'b1);
        $display("test pages done");
    endtask

    task automatic t_standby();
        standby_n = 1'b0;
        wait_cycles(3);
        u_host_bus_model.write_byte(1'b1, 6'h05, 8'h77);
        rd("standby read", 1'b1, 6'h05, 8'h00, 8'hff, 1'b0);
        standby_n = 1'b1;
        wait_cycles(3);
        rd("kept byte", 1'b1, 6'h05, 8'ha5, 8'hff, 1'b1);
        // Standby falls while the strobe is low: the write must not land.
        fork
            u_host_bus_model.write_byte(1'b1, 6'h05, 8'h66);
            begin
                wait_cycles(2);
                standby_n = 1'b0;
            end
        join
        standby_n = 1'b1;
        wait_cycles(3);
        rd("cut write", 1'b1, 6'h05, 8'ha5, 8'hff, 1'b1);
        $display("test standby done");
    endtask

    task automatic t_irq();
        cwr(LOC_REG_B, 8'h30);
        check("ctl b", 8'h30, ctl_b);
        pulse('{alarm: 1'b1, update_done: 1'b0, periodic: 1'b0});
        wait_cycles(4);
        check("irq oe", 8'h01, {7'h00, irq_oe});
        check("irq line", 8'h00, {7'h00, irq_line});
        crd("reg c alarm", LOC_REG_C, 8'ha0, 8'hff);
        check("irq released", 8'h01, {7'h00, irq_line});
        pulse('{alarm: 1'b0, update_done: 1'b1, periodic: 1'b0});
        crd("reg c update", LOC_REG_C, 8'h90, 8'hff);
        cwr(LOC_REG_B, 8'h00);
        pulse('{alarm: 1'b1, update_done: 1'b0, periodic: 1'b0});
        wait_cycles(4);
        check("masked irq oe", 8'h00, {7'h00, irq_oe});
        crd("masked summary", LOC_REG_C, 8'h00, 8'h80);
        $display("test irq done");
    endtask

    task automatic t_rate();
        int p3, p4;
        cwr(LOC_REG_B, 8'h48);
        cwr(LOC_REG_A, 8'h03);
        period(p3);
        crd("periodic flag", LOC_REG_C, 8'hc0, 8'hc0);
        cwr(LOC_REG_A, 8'h04);
        period(p4);
        check("rate halves", 8'h01, {7'h00, p4 == 2 * p3 && p3 > 0});
        cwr(LOC_REG_A, 8'h00);
        $display("test rate done");
    endtask

    task automatic t_pin_reset();
        cwr(LOC_REG_B, 8'h7f);
        pulse('{alarm: 1'b0, update_done: 1'b1, periodic: 1'b0});
        wait_cycles(4);
        check("irq before", 8'h01, {7'h00, irq_oe});
        reset_n = 1'b0;
        wait_cycles(4);
        check("ctl b cleared", 8'h07, ctl_b);
        check("irq floats", 8'h00, {7'h00, irq_oe});
        rd("locked read", 1'b0, 6'h01, 8'h00, 8'hff, 1'b0);
        reset_n = 1'b1;
        wait_cycles(4);
        crd("flags cleared", LOC_REG_C, 8'h00, 8'hf0);
        $display("test pin reset done");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        t_reset();
        t_index();
        t_readonly();
        t_pages();
        t_standby();
        t_irq();
        t_rate();
        t_pin_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
